// ---- dv/program_flow_props.sv ----
// Checker: counter, table read and register read timing of program_flow.
// Assumes it is bound onto program_flow and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module program_flow_props (
   input wire clk_sys,
   input wire rst,
   input wire step,
   input wire irq_accept,
   input wire ret_exec,
   input wire jump_en,
   input wire add_pcl,
   input wire [7:0] working_register,
   input wire reg_wr,
   input wire reg_rd,
   input wire [8:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire table_rd,
   input wire table_to_w,
   input wire [8:0] table_dest,
   input wire wdt_clear_exec,
   input wire [12:0] program_counter,
   input wire [12:0] flash_addr,
   input wire [7:0] reg_rdata,
   input wire table_wr,
   input wire [8:0] table_wr_addr,
   input wire w_load,
   input wire core_reset
);
   reg [4:0] hi_reg;
   reg [7:0] lo_reg;
   reg [4:0] latch_reg;
   wire pcl_wr = reg_wr && reg_addr == 9'h002;
   // Shadows, so no pointer or latch expectation is read back from the block
   always @(posedge clk_sys or posedge rst) begin
      if (rst || core_reset) begin
         hi_reg <= 5'h00;
         lo_reg <= 8'h00;
         latch_reg <= 5'h00;
      end else if (reg_wr) begin
         if (reg_addr == 9'h110) hi_reg <= reg_wdata[4:0];
         if (reg_addr == 9'h111) lo_reg <= reg_wdata;
         if (reg_addr == 9'h00a) latch_reg <= reg_wdata[4:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst || core_reset);
   irq_vector_a: assert property (irq_accept |=>
      program_counter == 13'h0004) else $error("bad irq vector");
   step_advance_a: assert property (step && !irq_accept && !pcl_wr
      && !add_pcl && !ret_exec && !jump_en |=> program_counter ==
      $past(program_counter) + 13'h0001) else $error("bad step");
   add_low_a: assert property (add_pcl && !irq_accept && !pcl_wr |=>
      program_counter == {latch_reg, $past(program_counter[7:0]) +
      $past(working_register)}) else $error("bad computed jump");
   pcl_write_a: assert property (pcl_wr && !irq_accept |=>
      program_counter == {latch_reg, $past(reg_wdata)})
      else $error("bad low byte write");
   table_addr_a: assert property (table_rd |=>
      flash_addr == {hi_reg, lo_reg}) else $error("bad table address");
   table_reg_a: assert property (table_rd && !table_to_w |-> ##3
      table_wr && !w_load && table_wr_addr == $past(table_dest, 3))
      else $error("bad table write");
   table_w_a: assert property (table_rd && table_to_w |-> ##3
      w_load && !table_wr) else $error("bad table load");
   ptr_read_a: assert property (reg_rd && reg_addr == 9'h111 |=>
      reg_rdata == lo_reg) else $error("bad pointer read");
   reset_hold_a: assert property (disable iff (rst)
      core_reset && $past(core_reset) |-> program_counter == 13'h0000)
      else $error("counter not at reset vector");
endmodule
bind program_flow program_flow_props u_props (.*);
`default_nettype wire

// ---- dv/tb_program_flow.sv ----
// Bench for program_flow: registers, table reads, counter and resets.
// Assumes the block and its checker are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb_program_flow;
   logic clk_sys, rst, por_n, wdt_timeout, brownout_reset, sleep_exec;
   logic wdt_clear_exec, step, irq_accept, ret_exec, jump_en, add_pcl;
   logic reg_wr, reg_rd, table_rd, table_to_w;
   logic [12:0] jump_addr;
   logic [7:0] working_register, reg_wdata;
   logic [8:0] reg_addr, table_dest;
   logic [15:0] flash_rdata;
   wire [12:0] program_counter, flash_addr;
   wire [7:0] reg_rdata, table_wr_data, w_load_data;
   wire [8:0] table_wr_addr;
   wire table_wr, w_load, core_reset, powerdown_flag, timeout_flag;
   int mismatches, compares;
   program_flow DUT (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Program word model: each address gives a distinct word
   always @(posedge clk_sys) begin
      flash_rdata <= {flash_addr[7:0] ^ 8'h5a, 3'h0, flash_addr[12:8]};
   end
   task tick;
      @(posedge clk_sys);
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [8:0] a, input logic [7:0] d);
      tick;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      tick;
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [8:0] a, input logic [7:0] e);
      tick;
      reg_rd <= 1'b1;
      reg_addr <= a;
      tick;
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // One strobe for one cycle: 0 step .. 6 watchdog clear
   task fire(input int k, input logic [12:0] a);
      tick;
      jump_addr <= a;
      {step, irq_accept, ret_exec, jump_en, add_pcl, sleep_exec,
         wdt_clear_exec} <= 7'h40 >> k;
      tick;
      {step, irq_accept, ret_exec, jump_en, add_pcl, sleep_exec,
         wdt_clear_exec} <= 7'h00;
      #1;
   endtask
   // Upper pointer bits set to 1 to prove they never reach the address
   task tread(input logic w, input logic [8:0] d, input logic [12:0] a);
      wr(9'h110, {3'h7, a[12:8]});
      wr(9'h111, a[7:0]);
      tick;
      table_rd <= 1'b1;
      table_to_w <= w;
      table_dest <= d;
      tick;
      table_rd <= 1'b0;
      // Result pulse stands only for the cycle after the data edge
      repeat (2) tick;
      #1;
      chk(w ? {w_load, w_load_data} : {table_wr, table_wr_data},
         {1'b1, 3'h0, a[12:8]});
      if (!w) chk(table_wr_addr, d);
      rd(9'h112, a[7:0] ^ 8'h5a);
   endtask
   task t_start;
      chk({program_counter, powerdown_flag, timeout_flag}, 16'h0003);
      rd(9'h110, 8'h00);
      rd(9'h112, 8'h00);
   endtask
   task t_regs;
      wr(9'h110, 8'hff);
      rd(9'h110, 8'h1f);
      wr(9'h111, 8'ha5);
      rd(9'h111, 8'ha5);
      wr(9'h112, 8'h77);
      rd(9'h112, 8'h00);
      rd(9'h1a0, 8'h00);
   endtask
   task t_table;
      tread(1'b0, 9'h021, 13'h0602);
      tread(1'b1, 9'h000, 13'h1fff);
   endtask
   task t_flow;
      fire(3, 13'h1ffe);
      fire(0, 13'h0000);
      fire(0, 13'h0000);
      chk(program_counter, 13'h0000);
      wr(9'h00a, 8'h01);
      fire(3, 13'h0110);
      tick;
      working_register <= 8'h05;
      fire(4, 13'h0000);
      chk(program_counter, 13'h0115);
      fire(0, 13'h0000);
      chk(program_counter, 13'h0116);
      fire(3, 13'h01f0);
      tick;
      working_register <= 8'h20;
      fire(4, 13'h0000);
      chk(program_counter, 13'h0110);
      wr(9'h002, 8'h33);
      chk(program_counter, 13'h0133);
      fire(1, 13'h0000);
      chk(program_counter, 13'h0004);
      fire(0, 13'h0000);
      fire(2, 13'h0000);
      chk(program_counter, 13'h0133);
   endtask
   task t_flags;
      fire(5, 13'h0000);
      chk({powerdown_flag, timeout_flag}, 2'b01);
      fire(6, 13'h0000);
      chk({powerdown_flag, timeout_flag}, 2'b11);
   endtask
   task t_src;
      int k;
      int n;
      for (k = 0; k < 3; k++) begin
         fire(0, 13'h0000);
         tick;
         {por_n, wdt_timeout, brownout_reset} <= k == 0 ? 3'b000 :
            (k == 1 ? 3'b110 : 3'b101);
         repeat (6) tick;
         #1;
         chk(core_reset, 1'b1);
         tick;
         {por_n, wdt_timeout, brownout_reset} <= 3'b100;
         for (n = 0; n < 20 && core_reset !== 1'b0; n++) tick;
         #1;
         chk({core_reset, program_counter}, 14'h0000);
         chk(timeout_flag, k != 1);
         if (k != 1) chk(powerdown_flag, 1'b1);
      end
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // The whole run is well under 2000 cycles
   initial begin
      #100000;
      mismatches++;
      end_of_test;
   end
   initial begin
      {rst, por_n, wdt_timeout, brownout_reset, sleep_exec} = 5'h18;
      {wdt_clear_exec, step, irq_accept, ret_exec, jump_en} = 5'h00;
      {add_pcl, reg_wr, reg_rd, table_rd, table_to_w} = 5'h00;
      {jump_addr, working_register, reg_wdata} = 29'h0;
      {reg_addr, table_dest} = 18'h0;
      mismatches = 0;
      compares = 0;
      repeat (16) tick;
      rst <= 1'b0;
      repeat (8) tick;
      #1;
      t_start;
      t_regs;
      t_table;
      t_flow;
      t_flags;
      t_src;
      end_of_test;
   end
endmodule
`default_nettype wire

// ---- src/flow_map.vh ----
// Constants for program-flow, vector and table-read logic.
// Assumes an 8-bit data bus addressed by 9-bit register addresses.
// Contract
// - 8K word space, wraps 1FFFH to 0000H
// - Power-on, watchdog, brownout resets act alike
// - Reset loads counter 0000H, defaults registers; code keeps 112H on watchdog, brownout, power-on
// - Powerdown and timeout flags record reset cause
// - Interrupt pushes counter, fetches from 0004H
// - All interrupts share vector 0004H
// - Only counter saved on interrupt entry
// - Table read to register: low byte, high byte
// - Table read to working register likewise
// - Pointer high at 110H, RW, five bits
// - Pointer low at 111H, RW, eight bits
// - High-byte result at 112H, read only
// - Add to counter low byte jumps
// - Counter advances by one after instruction
// - Low byte overflow does not carry upward
// - Low byte write takes upper bits from latch
`ifndef FLOW_MAP_VH
`define FLOW_MAP_VH
`define ADDR_PC_LOW 9'h002
`define ADDR_PC_LATCH 9'h00a
`define ADDR_STATUS 9'h003
`define ADDR_PTR_HIGH 9'h110
`define ADDR_PTR_LOW 9'h111
`define ADDR_HIGH_RESULT 9'h112
`define VEC_RESET 13'h0000
`define VEC_IRQ 13'h0004
`define STATUS_TO_BIT 4
`define STATUS_PD_BIT 3
`define PTR_HIGH_BITS 5
`define STACK_DEPTH 8
`endif

// ---- src/program_flow.v ----
// Program counter, vectors, reset cause flags and table-read unit.
// Assumes the decoder gives one-cycle strobes per executed instruction and
// reset-source pins come from other clock domains.
`timescale 1ns/1ps
`default_nettype none
`include "flow_map.vh"
module program_flow #(
   parameter AW = 13
) (
   input wire clk_sys,
   input wire rst,
   input wire por_n,
   input wire wdt_timeout,
   input wire brownout_reset,
   input wire sleep_exec,
   input wire wdt_clear_exec,
   input wire step,
   input wire irq_accept,
   input wire ret_exec,
   input wire jump_en,
   input wire [12:0] jump_addr,
   input wire [7:0] working_register,
   input wire add_pcl,
   input wire reg_wr,
   input wire reg_rd,
   input wire [8:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire table_rd,
   input wire table_to_w,
   input wire [8:0] table_dest,
   input wire [15:0] flash_rdata,
   output reg [12:0] program_counter,
   output reg [12:0] flash_addr,
   output reg [7:0] reg_rdata,
   output reg table_wr,
   output reg [8:0] table_wr_addr,
   output reg [7:0] table_wr_data,
   output reg w_load,
   output reg [7:0] w_load_data,
   output reg core_reset,
   output reg powerdown_flag,
   output reg timeout_flag
);
   reg [2:0] por_sync_reg;
   reg [2:0] wdt_sync_reg;
   reg [2:0] bor_sync_reg;
   reg [7:0] lookup_pointer_high;
   reg [7:0] lookup_pointer_low;
   reg [7:0] lookup_high_byte_result;
   reg [7:0] program_counter_high_latch;
   reg [1:0] tstate_reg;
   reg to_w_reg;
   reg [8:0] dest_reg;
   reg [12:0] pc_next;
   reg [7:0] rdata_next;
   wire [12:0] stack_top;
   wire [8:0] add_sum;
   wire src_reset;
   wire push_pc;
   localparam T_IDLE = 2'd0;
   localparam T_ADDR = 2'd1;
   localparam T_DATA = 2'd2;

   function [12:0] low_byte_jump;
      input [7:0] latch;
      input [7:0] low;
      begin
         low_byte_jump = {latch[4:0], low};
      end
   endfunction

   function sel;
      input [8:0] a;
      input [8:0] b;
      begin
         sel = (a == b);
      end
   endfunction

   // Three-stage synchronisers; a source counts as asserted only while stages two and three are both high
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         por_sync_reg <= 3'h7;
         wdt_sync_reg <= 3'h0;
         bor_sync_reg <= 3'h0;
      end else begin
         por_sync_reg <= {por_sync_reg[1:0], ~por_n};
         wdt_sync_reg <= {wdt_sync_reg[1:0], wdt_timeout};
         bor_sync_reg <= {bor_sync_reg[1:0], brownout_reset};
      end
   end

   // Any of the three sources resets the core identically
   assign src_reset = (por_sync_reg[2] & por_sync_reg[1]) |
      (wdt_sync_reg[2] & wdt_sync_reg[1]) |
      (bor_sync_reg[2] & bor_sync_reg[1]);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_reset <= 1'b1;
      end else begin
         core_reset <= src_reset;
      end
   end

   // Cause flags: power-on sets both; watchdog clears timeout; sleep clears
   // powerdown. Brownout sets both as power-on does; powerdown survives watchdog resets.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         powerdown_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (por_sync_reg[2] & por_sync_reg[1]) begin
         powerdown_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (wdt_sync_reg[2] & wdt_sync_reg[1]) begin
         timeout_flag <= 1'b0;
      end else if (bor_sync_reg[2] & bor_sync_reg[1]) begin
         powerdown_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end else if (sleep_exec) begin
         powerdown_flag <= 1'b0;
         timeout_flag <= 1'b1;
      end else if (wdt_clear_exec) begin
         powerdown_flag <= 1'b1;
         timeout_flag <= 1'b1;
      end
   end

   // Interrupt entry saves only the counter; W and status stay untouched
   assign push_pc = irq_accept & ~src_reset;

   // Ninth bit is the carry that the jump drops
   assign add_sum = {1'b0, program_counter[7:0]} + {1'b0, working_register};

   return_stack #(
      .DEPTH(`STACK_DEPTH),
      .AW(3)
   ) u_stack (
      .clk_sys(clk_sys),
      .rst(rst),
      .push(push_pc),
      .pop(ret_exec & ~irq_accept & ~src_reset),
      .din(program_counter),
      .dout(stack_top)
   );

   always @* begin
      pc_next = program_counter;
      if (irq_accept) begin
         pc_next = `VEC_IRQ;
      end else if (reg_wr && sel(reg_addr, `ADDR_PC_LOW)) begin
         pc_next = low_byte_jump(program_counter_high_latch, reg_wdata);
      end else if (add_pcl) begin
         // Carry out of the low byte is dropped
         pc_next = low_byte_jump(program_counter_high_latch,
            add_sum[7:0]);
      end else if (ret_exec) begin
         pc_next = stack_top;
      end else if (jump_en) begin
         pc_next = jump_addr;
      end else if (step) begin
         // 13-bit counter wraps 1FFFH to 0000H naturally
         pc_next = program_counter + 13'h0001;
      end
   end

   // Counter, latch and pointers return to defaults on any reset; the high-byte result only on rst
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         program_counter <= `VEC_RESET;
         program_counter_high_latch <= 8'h00;
         lookup_pointer_high <= 8'h00;
         lookup_pointer_low <= 8'h00;
      end else if (src_reset) begin
         program_counter <= `VEC_RESET;
         program_counter_high_latch <= 8'h00;
         lookup_pointer_high <= 8'h00;
         lookup_pointer_low <= 8'h00;
      end else begin
         program_counter <= pc_next;
         if (reg_wr && sel(reg_addr, `ADDR_PC_LATCH)) begin
            program_counter_high_latch <= reg_wdata;
         end
         if (reg_wr && sel(reg_addr, `ADDR_PTR_HIGH)) begin
            lookup_pointer_high <= {3'h0, reg_wdata[4:0]};
         end
         if (reg_wr && sel(reg_addr, `ADDR_PTR_LOW)) begin
            lookup_pointer_low <= reg_wdata;
         end
      end
   end

   // Register read port; unmapped addresses read as zero
   always @* begin
      rdata_next = 8'h00;
      if (sel(reg_addr, `ADDR_PTR_HIGH)) begin
         rdata_next = lookup_pointer_high;
      end else if (sel(reg_addr, `ADDR_PTR_LOW)) begin
         rdata_next = lookup_pointer_low;
      end else if (sel(reg_addr, `ADDR_HIGH_RESULT)) begin
         rdata_next = lookup_high_byte_result;
      end else if (sel(reg_addr, `ADDR_PC_LOW)) begin
         rdata_next = program_counter[7:0];
      end else if (sel(reg_addr, `ADDR_PC_LATCH)) begin
         rdata_next = program_counter_high_latch;
      end else if (sel(reg_addr, `ADDR_STATUS)) begin
         rdata_next[`STATUS_TO_BIT] = timeout_flag;
         rdata_next[`STATUS_PD_BIT] = powerdown_flag;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // Table read: address cycle, then data cycle writes both halves.
   // Pointers are sampled at the start; an interrupt handler that also
   // reads tables can corrupt them, which software must prevent.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tstate_reg <= T_IDLE;
         flash_addr <= 13'h0000;
         to_w_reg <= 1'b0;
         dest_reg <= 9'h000;
         table_wr <= 1'b0;
         table_wr_addr <= 9'h000;
         table_wr_data <= 8'h00;
         w_load <= 1'b0;
         w_load_data <= 8'h00;
         lookup_high_byte_result <= 8'h00;
      end else begin
         table_wr <= 1'b0;
         w_load <= 1'b0;
         case (tstate_reg)
            T_IDLE: begin
               if (table_rd && !src_reset) begin
                  flash_addr <= {lookup_pointer_high[`PTR_HIGH_BITS-1:0],
                     lookup_pointer_low};
                  to_w_reg <= table_to_w;
                  dest_reg <= table_dest;
                  tstate_reg <= T_ADDR;
               end
            end
            T_ADDR: begin
               tstate_reg <= T_DATA;
            end
            T_DATA: begin
               lookup_high_byte_result <= flash_rdata[15:8];
               if (to_w_reg) begin
                  w_load <= 1'b1;
                  w_load_data <= flash_rdata[7:0];
               end else begin
                  table_wr <= 1'b1;
                  table_wr_addr <= dest_reg;
                  table_wr_data <= flash_rdata[7:0];
               end
               tstate_reg <= T_IDLE;
            end
            default: begin
               tstate_reg <= T_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- src/return_stack.v ----
// Hardware return stack for the program counter.
// Assumes push and pop are never asserted together.
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_sys,
   input wire rst,
   input wire push,
   input wire pop,
   input wire [12:0] din,
   output wire [12:0] dout
);
   reg [12:0] mem [0:DEPTH-1];
   reg [AW-1:0] sp_reg;
   integer i;
   // Circular stack: overflow overwrites the oldest entry
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sp_reg <= {AW{1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= 13'h0000;
         end
      end else if (push) begin
         mem[sp_reg] <= din;
         sp_reg <= sp_reg + 1'b1;
      end else if (pop) begin
         sp_reg <= sp_reg - 1'b1;
      end
   end
   assign dout = mem[sp_reg - 1'b1];
endmodule
`default_nettype wire
